// File: hdl/stnp_top.sv
/*
 Serial-to-network packer: packs serial bytes into packets by time, size
 and trigger character, and runs connection control for four modes.
 Assumes serial and network sides are on clk; the network stack performs
 the actual connect, resolve and password checks and reports by pulses.
*/
`timescale 1ns/10ps
`include "stnp_params.svh"
module stnp_top
   import stnp_pkg::*;
#(
   parameter int MS_CYCLES = `STNP_MS_NS / `STNP_CLK_PERIOD_NS,
   parameter int DEPTH = `STNP_FIFO_DEPTH,
   parameter int CHANNEL = `STNP_CFG_CHANNEL
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Configuration
   input wire stnp_mode_t mode,
   input wire logic [15:0] idle_sec,
   input wire logic [15:0] pack_ms,
   input wire logic [7:0] pack_size,
   input wire logic [7:0] pack_char,
   input wire logic pw_en,
   input wire logic dns_en,
   input wire logic cfg_en,
   // Serial side
   input wire logic ser_valid,
   output logic ser_ready,
   input wire logic [7:0] ser_data,
   input wire logic cfg_entry_req,
   output logic cfg_mode,
   // Network packet stream
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [7:0] tx_data,
   output logic tx_last,
   // Network connection control
   input wire logic peer_req,
   input wire logic net_act,
   input wire logic close_req,
   input wire logic peer_closed,
   input wire logic conn_ok,
   input wire logic conn_fail,
   input wire logic dns_done,
   input wire logic pw_ok,
   input wire logic pw_bad,
   output logic listen,
   output logic conn_req,
   output logic dns_req,
   output logic peer_accept,
   output logic peer_refuse,
   output logic close_cmd,
   output logic link_up,
   output logic client_role
);
   initial
   begin
      if (MS_CYCLES < 1) $error("stnp_top: MS_CYCLES must be at least 1");
      if (DEPTH > 255) $error("stnp_top: DEPTH exceeds byte counters");
   end

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      stnp_state_t st;
      logic [7:0] pend;
      logic [7:0] due;
      logic [7:0] emit;
      logic [15:0] idle_ms;
      logic [15:0] idle_s;
      logic client;
      logic accept;
      logic refuse;
      logic close;
      logic cfg;
   } stnp_st_t;

   stnp_st_t s_r;
   stnp_st_t s_nxt;

   logic ms_tick;
   logic sec_tick;
   logic is_trig;
   logic fin_ready;
   logic fout_valid;
   logic push;
   logic pop;
   logic busy;
   logic open_now;
   logic [7:0] pend_n;
   logic [7:0] over;

   // ----------------------------------------
   // Dividers and buffer
   // ----------------------------------------
   stnp_tick #(.DIV(MS_CYCLES)) u_ms (
      .clk(clk),
      .rst_n(rst_n),
      .en(1'b1),
      .tick(ms_tick)
   );

   stnp_tick #(.DIV(`STNP_MS_PER_SEC)) u_sec (
      .clk(clk),
      .rst_n(rst_n),
      .en(ms_tick),
      .tick(sec_tick)
   );

   stnp_fifo #(.WIDTH(`STNP_DATA_W), .DEPTH(DEPTH)) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(ser_valid && !is_trig),
      .in_ready(fin_ready),
      .in_data(ser_data),
      .out_valid(fout_valid),
      .out_ready(tx_ready && link_up && s_r.emit != 8'h00),
      .out_data(tx_data)
   );

   assign is_trig = (pack_char != 8'h00) && (ser_data == pack_char);
   assign ser_ready = fin_ready || is_trig;
   assign push = ser_valid && fin_ready && !is_trig;
   assign link_up = (s_r.st == STNP_ST_OPEN);
   assign tx_valid = link_up && fout_valid && (s_r.emit != 8'h00);
   assign tx_last = (s_r.emit == 8'h01);
   assign pop = tx_valid && tx_ready;
   assign busy = (s_r.st == STNP_ST_OPEN) || (s_r.st == STNP_ST_AUTH);
   assign listen = (s_r.st == STNP_ST_WAIT) && !s_r.client
      && (mode == STNP_MODE_SERVER || mode == STNP_MODE_MIXED);
   assign conn_req = (s_r.st == STNP_ST_CONNECT);
   assign dns_req = (s_r.st == STNP_ST_RESOLVE);
   assign peer_accept = s_r.accept;
   assign peer_refuse = s_r.refuse;
   assign close_cmd = s_r.close;
   assign client_role = s_r.client;
   assign cfg_mode = s_r.cfg;
   assign pend_n = s_r.pend + 8'(push) - 8'(pop);
   assign over = pend_n - (s_r.due - 8'(pop));

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      s_nxt = s_r;
      open_now = 1'b0;
      s_nxt.accept = 1'b0;
      s_nxt.refuse = 1'b0;
      s_nxt.close = 1'b0;
      s_nxt.pend = pend_n;
      s_nxt.due = s_r.due - 8'(pop);
      if (pop) s_nxt.emit = s_r.emit - 8'h01;

      // Packing delimiters
      if (push) s_nxt.idle_ms = '0;
      else if (ms_tick && s_r.idle_ms != 16'hFFFF) s_nxt.idle_ms = s_r.idle_ms + 16'h0001;
      if (pack_ms == '0 && pack_size == '0 && pack_char == '0)
         s_nxt.due = pend_n;
      if (ser_valid && is_trig)
         s_nxt.due = pend_n;
      if (pack_ms != '0 && s_r.idle_ms >= pack_ms && over != 8'h00 && !push)
         s_nxt.due = pend_n;
      if (pack_size != '0 && over >= pack_size)
         s_nxt.due = s_nxt.due + pack_size;
      if (!fin_ready && s_r.due == 8'h00)
         s_nxt.due = pend_n;
      if (s_r.emit == 8'h00 && s_r.due != 8'h00 && !pop)
      begin
         if (pack_size != '0 && s_r.due > pack_size)
            s_nxt.emit = pack_size;
         else
            s_nxt.emit = s_r.due;
      end

      // Inactivity
      if (!link_up || push || pop || net_act) s_nxt.idle_s = '0;
      else if (sec_tick) s_nxt.idle_s = s_r.idle_s + 16'h0001;

      // Configuration mode entry
      if (cfg_entry_req && cfg_en && CHANNEL == 0) s_nxt.cfg = 1'b1;

      if (busy && peer_req) s_nxt.refuse = 1'b1;

      case (s_r.st)
         STNP_ST_WAIT:
         begin
            if (mode == STNP_MODE_UDP)
               s_nxt.st = STNP_ST_OPEN;
            else if (mode == STNP_MODE_CLIENT
               || (mode == STNP_MODE_MIXED && s_r.pend != 8'h00))
            begin
               s_nxt.client = 1'b1;
               s_nxt.st = dns_en ? STNP_ST_RESOLVE : STNP_ST_CONNECT;
            end
            else if (peer_req)
            begin
               s_nxt.client = 1'b0;
               s_nxt.accept = 1'b1;
               s_nxt.st = pw_en ? STNP_ST_AUTH : STNP_ST_OPEN;
            end
         end
         STNP_ST_RESOLVE:
         begin
            if (dns_done) s_nxt.st = STNP_ST_CONNECT;
         end
         STNP_ST_CONNECT:
         begin
            if (conn_ok) s_nxt.st = STNP_ST_OPEN;
            else if (conn_fail) s_nxt.st = STNP_ST_WAIT;
         end
         STNP_ST_AUTH:
         begin
            if (pw_ok) s_nxt.st = STNP_ST_OPEN;
            else if (pw_bad || peer_closed)
            begin
               s_nxt.close = 1'b1;
               s_nxt.st = STNP_ST_WAIT;
            end
         end
         STNP_ST_OPEN:
         begin
            open_now = 1'b1;
            if (mode != STNP_MODE_UDP
               && (close_req || peer_closed
               || (idle_sec != '0 && s_r.idle_s >= idle_sec)))
            begin
               s_nxt.close = 1'b1;
               s_nxt.client = 1'b0;
               s_nxt.st = STNP_ST_WAIT;
            end
            else if (mode == STNP_MODE_UDP && close_req)
               s_nxt.st = STNP_ST_WAIT;
         end
         default:
            s_nxt.st = STNP_ST_WAIT;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_r <= '0;
         s_r.st <= STNP_ST_WAIT;
      end
      else
         s_r <= s_nxt;
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence idle_expired;
      link_up && mode != STNP_MODE_UDP && idle_sec != '0 && s_r.idle_s >= idle_sec;
   endsequence

   a_idle_close: assert property (idle_expired |=> close_cmd && !link_up)
      else $error("idle interval expiry did not close");
   a_no_idle_zero: assert property (link_up && idle_sec == '0 && !close_req
      && !peer_closed |=> link_up)
      else $error("connection dropped with zero idle interval");
   a_busy_refuse: assert property (link_up && peer_req |=> peer_refuse && !peer_accept)
      else $error("second peer not refused");
   a_back_waiting: assert property (close_cmd |-> s_r.st == STNP_ST_WAIT)
      else $error("close did not return to waiting");
   a_trig_dropped: assert property (ser_valid && is_trig |-> !push)
      else $error("trigger character entered buffer");
   a_no_empty_pkt: assert property (tx_valid |-> s_r.pend != 8'h00)
      else $error("packet sent from empty buffer");
   a_size_limit: assert property (pack_size != '0 && tx_valid |-> s_r.emit <= pack_size)
      else $error("packet larger than size limit");
   a_byte_count: assert property (pop |=> s_r.pend == $past(s_r.pend) - 8'h01
      + 8'($past(push)))
      else $error("byte count slipped");
   a_server_wait: assert property (s_r.st == STNP_ST_WAIT && mode == STNP_MODE_SERVER
      && !s_r.client |-> listen)
      else $error("server not listening");
   a_udp_direct: assert property (s_r.st == STNP_ST_WAIT && mode == STNP_MODE_UDP
      |=> link_up && !conn_req)
      else $error("datagram mode did not open directly");
   a_auth_gate: assert property (s_r.st == STNP_ST_AUTH && !pw_ok |=> !link_up)
      else $error("access granted without password");
   a_cfg_chan: assert property (CHANNEL != 0 |-> !cfg_mode)
      else $error("config mode on second channel");
endmodule : stnp_top

// File: hdl/stnp_params.svh
/*
 Constants of the serial-to-network packer: timing, counts, widths.
 Assumes inclusion by stnp_pkg.sv and stnp_top; stnp_tick and stnp_fifo only import stnp_pkg.
*/
//
// Operation
// - Close connection after configured idle seconds
// - Zero idle interval keeps connection open
// - Refuse other peers while connection held
// - Return to waiting after idle close
// - All delimiters zero: forward bytes immediately
// - Send buffer after idle milliseconds elapse
// - No packet on timeout when empty
// - Send when buffer reaches size limit
// - Excess beyond size limit stays buffered
// - Trigger char flushes prior bytes, dropped
// - Any satisfied delimiter sends; rest stays
// - Server mode waits for peer connection
// - Client mode keeps trying to connect
// - Mixed: serial data first turns client
// - Mixed: after client close, serve again
// - Datagram mode sends without connecting
// - Config mode entry on channel zero only
// - Password required before server grants access
// - Resolve peer name before connecting
`ifndef STNP_PARAMS_SVH
`define STNP_PARAMS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define STNP_CLK_PERIOD_NS 8
`define STNP_MS_NS 1000000
`define STNP_MS_PER_SEC 1000

// ----------------------------------------
// Widths and sizes
// ----------------------------------------
`define STNP_FIFO_DEPTH 16
`define STNP_DATA_W 8
`define STNP_CNT_W 8
`define STNP_TIME_W 16
`define STNP_CFG_CHANNEL 0

`endif

// File: hdl/stnp_pkg.sv
/*
 Types of the serial-to-network packer.
 Assumes stnp_params.svh is on the include path.
*/
package stnp_pkg;
   `include "stnp_params.svh"

   typedef enum logic [1:0] {
      STNP_MODE_CLIENT = 2'h0,
      STNP_MODE_SERVER = 2'h1,
      STNP_MODE_MIXED = 2'h2,
      STNP_MODE_UDP = 2'h3
   } stnp_mode_t;

   // Gray codes along wait, resolve, connect, open
   typedef enum logic [2:0] {
      STNP_ST_WAIT = 3'h0,
      STNP_ST_RESOLVE = 3'h1,
      STNP_ST_CONNECT = 3'h3,
      STNP_ST_OPEN = 3'h2,
      STNP_ST_AUTH = 3'h6
   } stnp_state_t;
endpackage : stnp_pkg

// File: hdl/stnp_tick.sv
/*
 Enable divider: one-cycle pulse every DIV enabled cycles.
 Assumes a single clock; en is from the same domain.
*/
`timescale 1ns/10ps
module stnp_tick
   import stnp_pkg::*;
#(
   parameter int DIV = 1000
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Enable and tick
   input wire logic en,
   output logic tick
);
   localparam int W = (DIV > 1) ? $clog2(DIV) : 1;

   initial
   begin
      if (DIV < 1) $error("stnp_tick: DIV must be at least 1");
   end

   typedef struct packed {
      logic [W-1:0] cnt;
      logic tick;
   } stnp_tick_st_t;

   stnp_tick_st_t s_r;
   stnp_tick_st_t s_nxt;

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.tick = 1'b0;
      if (en)
      begin
         if (s_r.cnt == W'(DIV - 1))
         begin
            s_nxt.cnt = '0;
            s_nxt.tick = 1'b1;
         end
         else
         begin
            s_nxt.cnt = s_r.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign tick = s_r.tick;
endmodule : stnp_tick

// File: hdl/stnp_fifo.sv
/*
 Synchronous FIFO with valid/ready on both sides.
 Assumes one clock; out_data is read from mem_r at rd with no output register.
*/
`timescale 1ns/10ps
module stnp_fifo
   import stnp_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   initial
   begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("stnp_fifo: DEPTH must be a power of 2");
   end

   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
   } stnp_fifo_st_t;

   stnp_fifo_st_t s_r;
   stnp_fifo_st_t s_nxt;
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic push;
   logic pop;

   assign in_ready = (s_r.cnt != (AW+1)'(DEPTH));
   assign out_valid = (s_r.cnt != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_r[s_r.rd];

   always_comb
   begin
      s_nxt = s_r;
      if (push) s_nxt.wr = s_r.wr + 1'b1;
      if (pop) s_nxt.rd = s_r.rd + 1'b1;
      s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   always_ff @(posedge clk)
   begin
      if (push) mem_r[s_r.wr] <= in_data;
   end
endmodule : stnp_fifo

// File: sim/stnp_net_model.sv
/*
 Network side of the packer: stack answers to resolve and connect, packet sink.
 Assumes the packer's clk; slow makes tx_ready stall every other cycle.
*/
`timescale 1ns/10ps
module stnp_net_model
(
   // Clock
   input wire logic clk,
   // Stack requests and answers
   input wire logic dns_req,
   input wire logic conn_req,
   output logic dns_done,
   output logic conn_ok,
   // Packet sink
   input wire logic slow,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_last,
   output logic tx_ready
);
   logic [3:0] wait_r = 4'h0;
   logic [8:0] rx_q[$];

   initial
   begin
      dns_done = 1'h0;
      conn_ok = 1'h0;
      tx_ready = 1'h1;
   end

   // ----
   // Answer after five cycles, collect bytes
   // ----
   always @(posedge clk)
   begin
      dns_done <= 1'h0;
      conn_ok <= 1'h0;
      wait_r <= (dns_req || conn_req) ? wait_r + 4'h1 : 4'h0;
      if (wait_r == 4'h5)
      begin
         dns_done <= dns_req;
         conn_ok <= conn_req;
         wait_r <= 4'h0;
      end
      tx_ready <= slow ? ~tx_ready : 1'h1;
      if (tx_valid && tx_ready)
         rx_q.push_back({tx_last, tx_data});
   end
endmodule : stnp_net_model

// File: sim/tb_stnp_top.sv
/*
 Self-checking bench of the packer: serial bytes in, packets and pulses out.
 Assumes stnp_net_model stands in for the network stack and peer.
*/
`timescale 1ns/10ps
module tb_stnp_top
   import stnp_pkg::*;
;
   stnp_mode_t mode = STNP_MODE_SERVER;
   logic clk = 1'h0, rst_n = 1'h0, slow = 1'h0;
   logic [15:0] idle_sec = 16'h0000, pack_ms = 16'h0000;
   logic [7:0] pack_size = 8'h00, pack_char = 8'h00, ser_data = 8'h00, tx_data;
   logic pw_en = 1'h0, dns_en = 1'h0, cfg_en = 1'h0, ser_valid = 1'h0;
   logic cfg_entry_req = 1'h0, peer_req = 1'h0, net_act = 1'h0, close_req = 1'h0;
   logic peer_closed = 1'h0, conn_fail = 1'h0, pw_ok = 1'h0, pw_bad = 1'h0;
   logic ser_ready, cfg_mode, tx_valid, tx_ready, tx_last, conn_ok, dns_done;
   logic listen, conn_req, dns_req, peer_accept, peer_refuse, close_cmd;
   logic link_up, client_role;
   int err_count = 0, checked = 0, cycles = 0, i;

   always #4 clk = ~clk;

   // One channel only, so its local port stands alone
   stnp_top #(.MS_CYCLES(10)) dut (.clk(clk), .rst_n(rst_n), .mode(mode),
      .idle_sec(idle_sec), .pack_ms(pack_ms), .pack_size(pack_size),
      .pack_char(pack_char), .pw_en(pw_en), .dns_en(dns_en), .cfg_en(cfg_en),
      .ser_valid(ser_valid), .ser_ready(ser_ready), .ser_data(ser_data),
      .cfg_entry_req(cfg_entry_req), .cfg_mode(cfg_mode), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last),
      .peer_req(peer_req), .net_act(net_act), .close_req(close_req),
      .peer_closed(peer_closed), .conn_ok(conn_ok), .conn_fail(conn_fail),
      .dns_done(dns_done), .pw_ok(pw_ok), .pw_bad(pw_bad), .listen(listen),
      .conn_req(conn_req), .dns_req(dns_req), .peer_accept(peer_accept),
      .peer_refuse(peer_refuse), .close_cmd(close_cmd), .link_up(link_up),
      .client_role(client_role));

   stnp_net_model net (.clk(clk), .dns_req(dns_req), .conn_req(conn_req),
      .dns_done(dns_done), .conn_ok(conn_ok), .slow(slow), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));

   // ----
   // Access and compare tasks
   // ----
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic final_report;
      $display("mismatches %0d comparisons %0d", err_count, checked);
      if (err_count == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : final_report

   task automatic restart(input stnp_mode_t m);
      rst_n = 1'h0;
      mode = m;
      {idle_sec, pack_ms, pack_size, pack_char} = 48'h000000000000;
      {pw_en, dns_en, cfg_en, slow} = 4'h0;
      repeat (2) @(negedge clk);
      rst_n = 1'h1;
      net.rx_q.delete();
   endtask : restart

   task automatic peer;
      peer_req = 1'h1;
      @(negedge clk);
      peer_req = 1'h0;
   endtask : peer

   task automatic closing;
      close_req = 1'h1;
      @(negedge clk);
      close_req = 1'h0;
   endtask : closing

   // Held until ser_ready is seen high before the taking edge
   task automatic send(input logic [7:0] b);
      ser_valid = 1'h1;
      ser_data = b;
      #1;
      while (ser_ready !== 1'h1)
      begin
         @(negedge clk);
         #1;
      end
      @(negedge clk);
   endtask : send

   task automatic pkt(input logic [7:0] s, input int n);
      for (int j = 0; j < 400 && net.rx_q.size() < n; j++)
         @(negedge clk);
      chk("packet length", 16'(net.rx_q.size()), 16'(n));
      for (int j = 0; j < n; j++)
         chk("packet byte", {7'h00, net.rx_q[j]}, {7'h00, j == n - 1, s + j[7:0]});
      net.rx_q.delete();
   endtask : pkt

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         err_count++;
         final_report();
      end
   end

   // ----
   // Scenarios
   // ----
   initial
   begin
      repeat (16) @(negedge clk);
      rst_n = 1'h1;
      @(negedge clk);
      chk("listen", listen, 1'h1);
      peer();
      chk("accept", {peer_accept, link_up}, 2'h3);
      peer();
      chk("refuse", {peer_refuse, link_up}, 2'h3);
      send(8'hA0);
      ser_valid = 1'h0;
      pkt(8'hA0, 1);
      repeat (300) @(negedge clk);
      chk("no idle close", link_up, 1'h1);
      closing();
      chk("close", {close_cmd, link_up, listen}, 3'h5);

      restart(STNP_MODE_SERVER);
      pack_size = 8'h04;
      pack_char = 8'h0D;
      slow = 1'h1;
      peer();
      for (int k = 0; k < 6; k++)
         send(8'h10 + k[7:0]);
      ser_valid = 1'h0;
      pkt(8'h10, 4);
      repeat (50) @(negedge clk);
      chk("excess kept", 16'(net.rx_q.size()), 16'h0000);
      send(8'h0D);
      ser_valid = 1'h0;
      pkt(8'h14, 2);

      restart(STNP_MODE_SERVER);
      pack_size = 8'h20;
      for (int k = 0; k < 16; k++)
         send(8'h40 + k[7:0]);
      ser_valid = 1'h0;
      chk("full refuse", ser_ready, 1'h0);
      peer();
      pkt(8'h40, 16);
      peer_closed = 1'h1;
      @(negedge clk);
      peer_closed = 1'h0;
      chk("peer closed", {close_cmd, link_up, listen}, 3'h5);

      restart(STNP_MODE_SERVER);
      pack_ms = 16'h0005;
      peer();
      send(8'h20);
      ser_valid = 1'h0;
      repeat (25) @(negedge clk);
      send(8'h21);
      ser_valid = 1'h0;
      repeat (25) @(negedge clk);
      chk("idle restart", 16'(net.rx_q.size()), 16'h0000);
      pkt(8'h20, 2);
      repeat (200) @(negedge clk);
      chk("empty timeout", 16'(net.rx_q.size()), 16'h0000);

      restart(STNP_MODE_SERVER);
      idle_sec = 16'h0001;
      pw_en = 1'h1;
      peer();
      chk("auth", link_up, 1'h0);
      pw_ok = 1'h1;
      @(negedge clk);
      pw_ok = 1'h0;
      chk("granted", link_up, 1'h1);
      repeat (9000) @(negedge clk);
      chk("idle hold", link_up, 1'h1);
      for (i = 0; i < 2000 && close_cmd !== 1'h1; i++)
         @(negedge clk);
      chk("idle close", {close_cmd, link_up, listen}, 3'h5);

      restart(STNP_MODE_CLIENT);
      dns_en = 1'h1;
      repeat (2) @(negedge clk);
      chk("resolve first", {dns_req, conn_req}, 2'h2);
      for (i = 0; i < 50 && conn_req !== 1'h1; i++)
         @(negedge clk);
      chk("connect", {dns_req, conn_req}, 2'h1);
      conn_fail = 1'h1;
      @(negedge clk);
      conn_fail = 1'h0;
      chk("retry", {client_role, dns_req, conn_req}, 3'h4);
      for (i = 0; i < 50 && link_up !== 1'h1; i++)
         @(negedge clk);
      chk("client up", link_up, 1'h1);

      restart(STNP_MODE_UDP);
      repeat (2) @(negedge clk);
      chk("datagram", {link_up, conn_req}, 2'h2);
      send(8'h5A);
      ser_valid = 1'h0;
      pkt(8'h5A, 1);

      restart(STNP_MODE_MIXED);
      repeat (2) @(negedge clk);
      chk("mixed serve", listen, 1'h1);
      send(8'h30);
      ser_valid = 1'h0;
      for (i = 0; i < 50 && link_up !== 1'h1; i++)
         @(negedge clk);
      chk("mixed client", {client_role, link_up}, 2'h3);
      pkt(8'h30, 1);
      closing();
      @(negedge clk);
      chk("mixed back", {client_role, listen}, 2'h1);

      cfg_en = 1'h1;
      cfg_entry_req = 1'h1;
      @(negedge clk);
      cfg_entry_req = 1'h0;
      @(negedge clk);
      chk("config entry", cfg_mode, 1'h1);
      final_report();
   end
endmodule : tb_stnp_top
